// >>> design/pisd_pkg.sv
package pisd_pkg;

	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam logic [31:0] PISD_BASE_OFS   = 32'h5000_1400;
	localparam logic [31:0] PISD_SEL0_OFS   = 32'h5000_1400;
	localparam logic [31:0] PISD_SEL1_OFS   = 32'h5000_1402;
	localparam logic [31:0] PISD_SEL2_OFS   = 32'h5000_1404;
	localparam logic [31:0] PISD_SEL3_OFS   = 32'h5000_1406;
	localparam logic [31:0] PISD_SEL4_OFS   = 32'h5000_1408;
	localparam logic [31:0] PISD_DEB_OFS    = 32'h5000_140C;
	localparam logic [31:0] PISD_CLR_OFS    = 32'h5000_140E;
	localparam logic [31:0] PISD_LVL_OFS    = 32'h5000_1410;
	localparam logic [31:0] PISD_STAT_OFS   = 32'h5000_1420;
	localparam int          PISD_ADDR_W     = 8;

	// ---------------------------------------------------------------
	// Fields and reset values
	// ---------------------------------------------------------------
	localparam int          PISD_NCHAN      = 5;
	localparam int          PISD_NSRC       = 6;
	localparam int          PISD_NPIN       = 28;
	localparam int          PISD_SEL_W      = 6;
	localparam logic [15:0] PISD_SEL_MASK   = 16'h003F;
	localparam logic [15:0] PISD_DEB_MASK   = 16'h3F3F;
	localparam logic [15:0] PISD_LVL_MASK   = 16'h1F1F;
	localparam int          PISD_DEB_EN_LSB = 8;
	localparam int          PISD_DEB_KB_BIT = 13;
	localparam int          PISD_WAIT_LSB   = 8;
	localparam int          PISD_POL_LSB    = 0;
	localparam int          PISD_DLY_LSB    = 0;
	localparam int          PISD_CLR_LSB    = 0;
	localparam logic [15:0] PISD_RST_VAL    = 16'h0000;
	localparam logic [1:0]  PISD_RESP_OKAY  = 2'h0;
	localparam logic [1:0]  PISD_RESP_SLVERR = 2'h2;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int          PISD_CLK_NS     = 20;
	localparam int          PISD_TICK_NS    = 1000000;
	localparam int          PISD_TICK_CYC   = PISD_TICK_NS / PISD_CLK_NS;

	// ---------------------------------------------------------------
	// Carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic        awvalid;
		logic [31:0] awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [31:0] araddr;
		logic        rready;
	} pisd_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} pisd_axi_rsp_t;

	typedef struct packed {
		logic [3:0] port3;
		logic [9:0] port2;
		logic [5:0] port1;
		logic [7:0] port0;
	} pisd_pins_t;

endpackage : pisd_pkg

// >>> design/pisd_top.sv
`timescale 1ns/1ps

// What this block does
// RQ1 - Five channels, each with a 6-bit selector; code zero routes nothing.
// RQ2 - Codes 1 to 8 pick port 0 pins 0 to 7.
// RQ3 - Codes 9 to 14 pick port 1 pins 0 to 5.
// RQ4 - Codes 15 to 24 pick port 2 pins 0 to 9.
// RQ5 - Codes 25 to 28 pick port 3 pins 0 to 3.
// RQ6 - Debounce enables in bits 8 to 12 gate each channel's counter.
// RQ7 - Bit 13 enables the debounce counter of the keypad path.
// RQ8 - With debounce on, keypad event rises after N times 1 ms, N 0 to 63.
// RQ9 - With debounce off, the event is raised without the delay.
// RQ10 - Polarity bit: zero fires on high input, one fires on low input.
// RQ11 - Mode bit: zero refires at once, one waits for release after clear.
// RQ12 - Writing one to a clear bit clears that pending event; reads return zero.
// RQ13 - Pins are synchronised first; delays count a 1 ms prescaler tick.
module pisd_top
	import pisd_pkg::*;
#(
	parameter int TICK_CYCLES = pisd_pkg::PISD_TICK_CYC
) (
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	input  wire pisd_pkg::pisd_axi_req_t axi_req,
	output      pisd_pkg::pisd_axi_rsp_t axi_rsp,
	input  wire pisd_pkg::pisd_pins_t    port_pins,
	input  wire logic                    keypad_raw,
	output      logic [4:0]              chan_pending,
	output      logic                    keypad_event
);
	import pisd_pkg::*;

	localparam int TW = $clog2(TICK_CYCLES + 1);

	// ---------------------------------------------------------------
	// Functions
	// ---------------------------------------------------------------
	function automatic logic [PISD_ADDR_W-1:0] reg_addr(input logic [31:0] ofs);
		logic [31:0] idx;
		idx = ofs - PISD_BASE_OFS;
		reg_addr = PISD_ADDR_W'(idx << 2);
	endfunction : reg_addr

	function automatic logic pick_pin(input logic [PISD_NPIN-1:0] pins,
		input logic [PISD_SEL_W-1:0] code);
		logic [PISD_SEL_W-1:0] ix;
		ix = code - 6'h01;
		if (code == 6'h00 || code > 6'h1C) begin
			pick_pin = 1'b0;
		end else begin
			pick_pin = pins[ix[4:0]];
		end
	endfunction : pick_pin

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] st, input logic [15:0] mask);
		logic [15:0] v;
		v = old;
		if (st[0]) begin
			v[7:0] = wd[7:0];
		end
		if (st[1]) begin
			v[15:8] = wd[15:8];
		end
		merge16 = v & mask;
	endfunction : merge16

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic [PISD_SEL_W-1:0]  sel_q [PISD_NCHAN];
	logic [15:0]            deb_q;
	logic [15:0]            lvl_q;
	logic                   aw_got_q;
	logic                   w_got_q;
	logic                   bvalid_q;
	logic                   rvalid_q;
	logic                   awready_q;
	logic                   wready_q;
	logic                   arready_q;
	logic [PISD_ADDR_W-1:0] waddr_q;
	logic [31:0]            wdata_q;
	logic [3:0]             wstrb_q;
	logic [1:0]             bresp_q;
	logic [1:0]             rresp_q;
	logic [31:0]            rdata_q;

	// ---------------------------------------------------------------
	// Write channel
	// ---------------------------------------------------------------
	wire logic aw_take  = axi_req.awvalid & awready_q;
	wire logic w_take   = axi_req.wvalid & wready_q;
	wire logic do_write = aw_got_q & w_got_q;
	wire logic aw_got_d = (aw_got_q | aw_take) & ~do_write;
	wire logic w_got_d  = (w_got_q | w_take) & ~do_write;
	wire logic bvalid_d = do_write | (bvalid_q & ~axi_req.bready);

	wire logic wr_sel0 = do_write && waddr_q == reg_addr(PISD_SEL0_OFS);
	wire logic wr_sel1 = do_write && waddr_q == reg_addr(PISD_SEL1_OFS);
	wire logic wr_sel2 = do_write && waddr_q == reg_addr(PISD_SEL2_OFS);
	wire logic wr_sel3 = do_write && waddr_q == reg_addr(PISD_SEL3_OFS);
	wire logic wr_sel4 = do_write && waddr_q == reg_addr(PISD_SEL4_OFS);
	wire logic wr_deb  = do_write && waddr_q == reg_addr(PISD_DEB_OFS);
	wire logic wr_clr  = do_write && waddr_q == reg_addr(PISD_CLR_OFS);
	wire logic wr_lvl  = do_write && waddr_q == reg_addr(PISD_LVL_OFS);
	wire logic wr_stat = do_write && waddr_q == reg_addr(PISD_STAT_OFS);
	wire logic [4:0] wr_sel = {wr_sel4, wr_sel3, wr_sel2, wr_sel1, wr_sel0};
	wire logic wr_hit  = (|wr_sel) | wr_deb | wr_clr | wr_lvl | wr_stat;

	// Low byte lane only carries the clear bits
	wire logic [PISD_NSRC-1:0] clr = (wr_clr && wstrb_q[0]) ?
		wdata_q[PISD_CLR_LSB +: PISD_NSRC] : 6'h00;  // [RQ12]

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q  <= 1'b0;
			w_got_q   <= 1'b0;
			bvalid_q  <= 1'b0;
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			bresp_q   <= PISD_RESP_OKAY;
			waddr_q   <= '0;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
		end else begin
			aw_got_q  <= aw_got_d;
			w_got_q   <= w_got_d;
			bvalid_q  <= bvalid_d;
			// Readies stay low while a response is open: one write in flight
			awready_q <= ~aw_got_d & ~bvalid_d;
			wready_q  <= ~w_got_d & ~bvalid_d;
			if (aw_take) begin
				waddr_q <= axi_req.awaddr[PISD_ADDR_W-1:0];
			end
			if (w_take) begin
				wdata_q <= axi_req.wdata;
				wstrb_q <= axi_req.wstrb;
			end
			// Status writes count as hits, so software sees OKAY and no change
			if (do_write) begin
				bresp_q <= wr_hit ? PISD_RESP_OKAY : PISD_RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < PISD_NCHAN; i++) begin
				sel_q[i] <= '0;
			end
			deb_q <= PISD_RST_VAL;
			lvl_q <= PISD_RST_VAL;
		end else begin
			for (int i = 0; i < PISD_NCHAN; i++) begin
				if (wr_sel[i]) begin
					sel_q[i] <= PISD_SEL_W'(merge16({10'h000, sel_q[i]}, wdata_q,
						wstrb_q, PISD_SEL_MASK));  // [RQ1]
				end
			end
			if (wr_deb) begin
				deb_q <= merge16(deb_q, wdata_q, wstrb_q, PISD_DEB_MASK);
			end
			if (wr_lvl) begin
				lvl_q <= merge16(lvl_q, wdata_q, wstrb_q, PISD_LVL_MASK);
			end
		end
	end

	// ---------------------------------------------------------------
	// Read channel
	// ---------------------------------------------------------------
	logic [PISD_NSRC-1:0] pend_q;

	wire logic [PISD_ADDR_W-1:0] raddr = axi_req.araddr[PISD_ADDR_W-1:0];
	wire logic ar_take  = axi_req.arvalid & arready_q;
	wire logic rvalid_d = ar_take | (rvalid_q & ~axi_req.rready);
	wire logic rd_sel0  = raddr == reg_addr(PISD_SEL0_OFS);
	wire logic rd_sel1  = raddr == reg_addr(PISD_SEL1_OFS);
	wire logic rd_sel2  = raddr == reg_addr(PISD_SEL2_OFS);
	wire logic rd_sel3  = raddr == reg_addr(PISD_SEL3_OFS);
	wire logic rd_sel4  = raddr == reg_addr(PISD_SEL4_OFS);
	wire logic rd_deb   = raddr == reg_addr(PISD_DEB_OFS);
	wire logic rd_clr   = raddr == reg_addr(PISD_CLR_OFS);
	wire logic rd_lvl   = raddr == reg_addr(PISD_LVL_OFS);
	wire logic rd_stat  = raddr == reg_addr(PISD_STAT_OFS);
	wire logic rd_hit   = rd_sel0 | rd_sel1 | rd_sel2 | rd_sel3 | rd_sel4 | rd_deb
		| rd_clr | rd_lvl | rd_stat;
	// Clear register reads as zero
	wire logic [31:0] rd_mux =
		rd_sel0 ? {26'h0, sel_q[0]} :
		rd_sel1 ? {26'h0, sel_q[1]} :
		rd_sel2 ? {26'h0, sel_q[2]} :
		rd_sel3 ? {26'h0, sel_q[3]} :
		rd_sel4 ? {26'h0, sel_q[4]} :
		rd_deb  ? {16'h0, deb_q} :
		rd_lvl  ? {16'h0, lvl_q} :
		rd_stat ? {26'h0, pend_q} : 32'h0000_0000;  // [RQ12]

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q  <= 1'b0;
			arready_q <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= PISD_RESP_OKAY;
		end else begin
			rvalid_q  <= rvalid_d;
			arready_q <= ~rvalid_d;
			if (ar_take) begin
				rdata_q <= rd_mux;
				rresp_q <= rd_hit ? PISD_RESP_OKAY : PISD_RESP_SLVERR;
			end
		end
	end

	assign axi_rsp = '{awready: awready_q, wready: wready_q, bvalid: bvalid_q,
		bresp: bresp_q, arready: arready_q, rvalid: rvalid_q, rdata: rdata_q,
		rresp: rresp_q};

	// ---------------------------------------------------------------
	// Pin synchroniser and 1 ms tick
	// ---------------------------------------------------------------
	// Three stages; a level is taken once stages two and three agree
	logic [PISD_NPIN:0] s1_q;
	logic [PISD_NPIN:0] s2_q;
	logic [PISD_NPIN:0] s3_q;
	logic [PISD_NPIN:0] stab_q;
	logic [TW-1:0]      pre_q;
	logic               tick_q;

	wire logic [PISD_NPIN:0] raw_in = {keypad_raw, port_pins};
	wire logic [PISD_NPIN:0] agree  = ~(s2_q ^ s3_q);
	// Tick runs free, so a delay of N ms may end up to one tick early
	wire logic               pre_end = pre_q == TW'(TICK_CYCLES - 1);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_q   <= '0;
			s2_q   <= '0;
			s3_q   <= '0;
			stab_q <= '0;
			pre_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			s1_q   <= raw_in;  // [RQ13]
			s2_q   <= s1_q;
			s3_q   <= s2_q;
			stab_q <= (agree & s3_q) | (~agree & stab_q);
			pre_q  <= pre_end ? '0 : pre_q + TW'(1);  // [RQ13]
			tick_q <= pre_end;
		end
	end

	// ---------------------------------------------------------------
	// Source detect, debounce and pending
	// ---------------------------------------------------------------
	logic [PISD_SEL_W-1:0] cnt_q [PISD_NSRC];
	logic [PISD_NSRC-1:0]  qual_prev_q;

	wire logic [PISD_NPIN-1:0] pins_s = stab_q[PISD_NPIN-1:0];
	wire logic [PISD_NSRC-1:0] lvl_in = {stab_q[PISD_NPIN],
		pick_pin(pins_s, sel_q[4]), pick_pin(pins_s, sel_q[3]),
		pick_pin(pins_s, sel_q[2]), pick_pin(pins_s, sel_q[1]),
		pick_pin(pins_s, sel_q[0])};  // [RQ1] [RQ2] [RQ3] [RQ4] [RQ5]
	wire logic [PISD_NSRC-1:0] pol    = {1'b0, lvl_q[PISD_POL_LSB +: PISD_NCHAN]};
	wire logic [PISD_NSRC-1:0] active = lvl_in ^ pol;  // [RQ10]
	wire logic [PISD_NSRC-1:0] filt_on = {deb_q[PISD_DEB_KB_BIT],
		deb_q[PISD_DEB_EN_LSB +: PISD_NCHAN]};  // [RQ6] [RQ7]
	wire logic [PISD_NSRC-1:0] wait_rel = {1'b0, lvl_q[PISD_WAIT_LSB +: PISD_NCHAN]};
	wire logic [PISD_SEL_W-1:0] delay_n = deb_q[PISD_DLY_LSB +: PISD_SEL_W];

	logic [PISD_NSRC-1:0] qual;
	logic [PISD_NSRC-1:0] fire;

	always_comb begin
		for (int i = 0; i < PISD_NSRC; i++) begin
			qual[i] = active[i] & (~filt_on[i] | (cnt_q[i] >= delay_n));  // [RQ8] [RQ9]
			// Level mode refires while held; wait mode needs a fresh assertion
			fire[i] = qual[i] & (~wait_rel[i] | ~qual_prev_q[i]);  // [RQ11]
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < PISD_NSRC; i++) begin
				cnt_q[i] <= '0;
			end
			qual_prev_q <= '0;
			pend_q      <= '0;
		end else begin
			for (int i = 0; i < PISD_NSRC; i++) begin
				if (!active[i] || !filt_on[i]) begin
					cnt_q[i] <= '0;  // [RQ6]
				end else if (tick_q && cnt_q[i] < delay_n) begin
					cnt_q[i] <= cnt_q[i] + 6'h01;  // [RQ8]
				end
			end
			qual_prev_q <= qual;
			pend_q      <= (pend_q & ~clr) | fire;  // [RQ12]
		end
	end

	assign chan_pending = pend_q[PISD_NCHAN-1:0];
	assign keypad_event = pend_q[PISD_NCHAN];

endmodule : pisd_top

// >>> verification/pin_interrupt_select_debounce_test.sv
`timescale 1ns/1ps
module pin_interrupt_select_debounce_test;
	import pisd_pkg::*;
	// ------
	// Bench
	// ------
	localparam int TICK  = 4;
	localparam int LIMIT = 6000;
	logic          aclk;
	logic          aresetn;
	logic          bouncy;
	logic [28:0]   cmd;
	pisd_axi_req_t req;
	pisd_axi_rsp_t rsp;
	pisd_pins_t    pins;
	logic          kraw;
	logic          kev;
	logic [4:0]    pend;
	logic [31:0]   rd_q;
	logic [1:0]    resp_q;
	int            mismatches;
	int            compares;
	int            cyc;

	pisd_top #(.TICK_CYCLES(TICK)) dut (.aclk(aclk), .aresetn(aresetn), .axi_req(req),
		.axi_rsp(rsp), .port_pins(pins), .keypad_raw(kraw), .chan_pending(pend),
		.keypad_event(kev));
	pisd_pins_model u_pins (.aclk(aclk), .aresetn(aresetn), .level_cmd(cmd),
		.bouncy(bouncy), .port_pins(pins), .keypad_raw(kraw));

	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			mismatches++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_of_test

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	function automatic logic [31:0] ba(input logic [31:0] ofs);
		return (ofs - PISD_BASE_OFS) << 2;
	endfunction : ba

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge aclk);
		req.awvalid <= 1'b1;
		req.awaddr  <= a;
		req.wvalid  <= 1'b1;
		req.wdata   <= d;
		req.wstrb   <= 4'hF;
		req.bready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
		end while (!rsp.bvalid);
		req.bready <= 1'b0;
		resp_q = rsp.bresp;
	endtask : wr

	task automatic rd(input logic [31:0] a);
		@(posedge aclk);
		req.arvalid <= 1'b1;
		req.araddr  <= a;
		req.rready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (rsp.arready) req.arvalid <= 1'b0;
		end while (!rsp.rvalid);
		req.rready <= 1'b0;
		rd_q = rsp.rdata;
		resp_q = rsp.rresp;
	endtask : rd

	task automatic drive(input logic [28:0] v, input int n);
		@(posedge aclk);
		cmd <= v;
		repeat (n) @(posedge aclk);
	endtask : drive

	// ------
	// Scenarios
	// ------
	task automatic t_reset();
		for (int i = 0; i < 5; i++) begin
			rd(ba(PISD_SEL0_OFS + 32'(2 * i)));
			chk("sel reset", 32'h0, rd_q);
		end
		rd(ba(PISD_DEB_OFS));
		chk("deb reset", 32'h0, rd_q);
		drive(29'h0FFF_FFFF, 12);
		chk("code zero", 32'h0, {27'h0, pend});
		drive(29'h0, 8);
	endtask : t_reset

	task automatic t_route();
		for (int c = 1; c <= PISD_NPIN; c++) begin
			wr(ba(PISD_SEL0_OFS + 32'(2 * (c % 5))), 32'(c));
			rd(ba(PISD_SEL0_OFS + 32'(2 * (c % 5))));
			chk("sel read", 32'(c), rd_q);
			drive(29'h1 << (c - 1), 12);
			chk("route", 32'h1 << (c % 5), {27'h0, pend});
			drive(29'h0, 8);
			wr(ba(PISD_CLR_OFS), 32'h1F);
			drive(29'h0, 2);
			chk("clear", 32'h0, {27'h0, pend});
		end
	endtask : t_route

	task automatic t_level();
		wr(ba(PISD_SEL0_OFS), 32'h1);
		wr(ba(PISD_LVL_OFS), 32'h0001);
		drive(29'h0, 12);
		chk("low fires", 32'h1, {31'h0, pend[0]});
		wr(ba(PISD_CLR_OFS), 32'h1);
		drive(29'h0, 4);
		chk("refire", 32'h1, {31'h0, pend[0]});
		wr(ba(PISD_LVL_OFS), 32'h0101);
		rd(ba(PISD_LVL_OFS));
		chk("lvl read", 32'h0101, rd_q);
		wr(ba(PISD_CLR_OFS), 32'h1);
		drive(29'h0, 12);
		chk("wait release", 32'h0, {31'h0, pend[0]});
		drive(29'h1, 12);
		drive(29'h0, 12);
		chk("new press", 32'h1, {31'h0, pend[0]});
		wr(ba(PISD_LVL_OFS), 32'h0);
		wr(ba(PISD_CLR_OFS), 32'h1F);
	endtask : t_level

	task automatic t_filter();
		bouncy <= 1'b1;
		wr(ba(PISD_DEB_OFS), 32'h2103);
		rd(ba(PISD_DEB_OFS));
		chk("deb read", 32'h2103, rd_q);
		drive(29'h1000_0001, 15);
		chk("key early", 32'h0, {31'h0, kev});
		chk("chan early", 32'h0, {31'h0, pend[0]});
		drive(29'h1000_0001, 40);
		chk("key late", 32'h1, {31'h0, kev});
		chk("chan late", 32'h1, {31'h0, pend[0]});
		rd(ba(PISD_STAT_OFS));
		chk("status", 32'h21, rd_q);
		bouncy <= 1'b0;
		drive(29'h0, 8);
		wr(ba(PISD_DEB_OFS), 32'h0003);
		wr(ba(PISD_CLR_OFS), 32'h21);
		drive(29'h1000_0001, 9);
		chk("key fast", 32'h1, {31'h0, kev});
		chk("chan fast", 32'h1, {31'h0, pend[0]});
	endtask : t_filter

	task automatic t_bus();
		rd(32'hFC);
		chk("unmapped rresp", {30'h0, PISD_RESP_SLVERR}, {30'h0, resp_q});
		chk("unmapped rdata", 32'h0, rd_q);
		wr(32'hFC, 32'hFFFF);
		chk("unmapped bresp", {30'h0, PISD_RESP_SLVERR}, {30'h0, resp_q});
		rd(ba(PISD_CLR_OFS));
		chk("clear read", 32'h0, rd_q);
	endtask : t_bus

	initial begin
		aresetn = 1'b0;
		bouncy  = 1'b0;
		cmd     = 29'h0;
		req     = '0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_route();
		t_level();
		t_filter();
		t_bus();
		end_of_test();
	end
endmodule : pin_interrupt_select_debounce_test

// >>> verification/pisd_pins_model.sv
`timescale 1ns/1ps
module pisd_pins_model
	import pisd_pkg::*;
(
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic [28:0]          level_cmd,
	input  wire logic                 bouncy,
	output      pisd_pkg::pisd_pins_t port_pins,
	output      logic                 keypad_raw
);
	// ------
	// Contact model
	// ------
	logic [28:0] lvl_q;
	logic [28:0] chg_q;
	logic [2:0]  bnc_q;
	wire         start = bouncy && (level_cmd != lvl_q);
	// Chatter flips every cycle, so the synchroniser holds the old level and settling moves later
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lvl_q <= 29'h0;
			chg_q <= 29'h0;
			bnc_q <= 3'h0;
		end else begin
			lvl_q <= level_cmd;
			chg_q <= start ? (level_cmd ^ lvl_q) : chg_q;
			bnc_q <= start ? 3'h5 : bnc_q - {2'h0, |bnc_q};
		end
	end
	assign {keypad_raw, port_pins} = lvl_q ^ (chg_q & {29{bnc_q[0]}});
endmodule : pisd_pins_model

// >>> verification/pisd_props.sv
`timescale 1ns/1ps
module pisd_props
	import pisd_pkg::*;
(
	input wire logic                    aclk,
	input wire logic                    aresetn,
	input wire pisd_pkg::pisd_axi_req_t axi_req,
	input wire pisd_pkg::pisd_axi_rsp_t axi_rsp,
	input wire pisd_pkg::pisd_pins_t    port_pins,
	input wire logic                    keypad_raw,
	input wire logic [4:0]              chan_pending,
	input wire logic                    keypad_event
);
	// ------
	// Helpers
	// ------
	wire pisd_axi_req_t q    = axi_req;
	wire pisd_axi_rsp_t s    = axi_rsp;
	wire                w_hs = q.awvalid && s.awready && q.wvalid && s.wready;
	wire                b_hs = s.bvalid && q.bready;
	wire                r_hs = q.arvalid && s.arready;
	logic [7:0]         raw_q;
	// Short history is enough: a filtered key must stay pressed
	always_ff @(posedge aclk)
		raw_q <= aresetn ? {raw_q[6:0], keypad_raw} : 8'h0;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_b_late; !s.bvalid ##1 s.bvalid; endsequence
	sequence s_w_free; !s.bvalid ##[0:1] (s.awready && s.wready); endsequence
	// ------
	// Properties
	// ------
	AST_B_LATE: assert property (w_hs |=> s_b_late)
		else $error("write response timing wrong");
	AST_B_HOLD: assert property (s.bvalid && !q.bready |=> s.bvalid && $stable(s.bresp))
		else $error("write response not held");
	AST_B_REFUSE: assert property (s.bvalid |-> !s.awready && !s.wready)
		else $error("write taken while response open");
	AST_B_FREE: assert property (b_hs |=> s_w_free)
		else $error("write channel not released");
	AST_R_LATE: assert property (r_hs |=> s.rvalid && !s.arready)
		else $error("read response timing wrong");
	AST_R_HOLD: assert property (s.rvalid && !q.rready |=> s.rvalid && $stable(s.rdata))
		else $error("read data not held");
	AST_UNMAP: assert property (r_hs && q.araddr[7:0] == 8'hFC |=>
		s.rresp == PISD_RESP_SLVERR && s.rdata == 32'h0)
		else $error("unmapped read not refused");
	AST_CLR_RD0: assert property (r_hs && q.araddr[7:0] == 8'h38 |=> s.rdata == 32'h0)
		else $error("clear register read not zero");
	AST_KEY_CAUSE: assert property ($rose(keypad_event) |-> |raw_q)
		else $error("keypad event without key");
endmodule : pisd_props

bind pisd_top pisd_props u_props (
	.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
	.port_pins(port_pins), .keypad_raw(keypad_raw), .chan_pending(chan_pending),
	.keypad_event(keypad_event));
